// ---- vcrc_ctrl.sv ----
// Functional notes
// - The channel map is eight bits at 7:0, resets to all ones, bit 0 fixed.
// - Each set map bit routes that traffic class onto the channel.
// - Writing one to bit 16 loads the staged table; writing zero does nothing.
// - Bit 16 always reads back as zero.
// - The load trigger only acts in the upstream port.
// - A load only happens when the selected scheme uses the table.
// - Table status sets on a table write, clears at load end, zero downstream.
// - The scheme select is three bits at 19:17, resets to zero, drives arbitration.
// - Capability is 0x3 upstream (round robin and WRR32), 0x1 downstream.
// - The channel identifier at 26:24 reads zero and is read-only.
// - The channel enable at bit 31 reads one and is read-only.
`timescale 1ns/1ps
module vcrc_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire vcrc_pkg::vcrc_apb_req_t apb_req,
  output vcrc_pkg::vcrc_apb_rsp_t apb_rsp,
  input wire logic port_is_upstream_pin,
  output logic [7:0] class_to_channel_map,
  output logic [2:0] arb_scheme_select,
  output logic [2:0] channel_identifier,
  output logic channel_enable,
  output logic [31:0] arb_table_active,
  output logic arb_table_status
);
  import vcrc_pkg::*;

  typedef struct packed {
    logic [7:1] map;
    logic [2:0] sel;
    logic [31:0] tbl;
    logic status;
    logic [2:0] sync;
    logic upstream;
    logic load;
    logic [31:0] prdata;
    logic pslverr;
  } vcrc_ctrl_st_t;

  vcrc_ctrl_st_t st_q;
  vcrc_ctrl_st_t st_d;
  logic setup_ph;
  logic wr_acc;
  logic wr_ctrl;
  logic wr_tbl;
  logic ld_busy;
  logic ld_done;
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero-wait slave; writes land on the access edge
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wr_ctrl = wr_acc && (apb_req.paddr == VCRC_OFF_CTRL);
  assign wr_tbl = wr_acc && (apb_req.paddr == VCRC_OFF_TBL);

  // Control word image; load bit and reserved ranges read zero
  always_comb begin
    ctrl_val = 32'h0;
    ctrl_val[VCRC_MAP_LSB +: 8] = {st_q.map, 1'b1};
    ctrl_val[VCRC_LOAD_BIT] = 1'b0;
    ctrl_val[VCRC_SEL_LSB +: 3] = st_q.sel;
    ctrl_val[VCRC_ID_LSB +: 3] = VCRC_ID_VAL;
    ctrl_val[VCRC_EN_BIT] = VCRC_EN_VAL;
  end

  // Status word image, polled by software during a load
  always_comb begin
    stat_val = 32'h0;
    stat_val[VCRC_STAT_BIT] = st_q.status;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Strap synchroniser; only the agreed level is used
    st_d.sync = {st_q.sync[1:0], port_is_upstream_pin};
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.upstream = st_q.sync[2];
    end
    // Read data and error captured in the setup cycle
    if (setup_ph) begin
      st_d.pslverr = 1'b0;
      st_d.prdata = 32'h0;
      if (apb_req.paddr == VCRC_OFF_CTRL) begin
        st_d.prdata = ctrl_val;
      end else if (apb_req.paddr == VCRC_OFF_STAT) begin
        st_d.prdata = stat_val;
      end else if (apb_req.paddr == VCRC_OFF_TBL) begin
        st_d.prdata = st_q.tbl;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end
    // Control write; bit 0 of the map and reserved bits ignored
    st_d.load = 1'b0;
    if (wr_ctrl) begin
      st_d.map = apb_req.pwdata[7:1];
      st_d.sel = apb_req.pwdata[VCRC_SEL_LSB +: 3];
      if (apb_req.pwdata[VCRC_LOAD_BIT] && st_q.upstream
          && vcrc_table_used(st_q.upstream,
                             apb_req.pwdata[VCRC_SEL_LSB +: 3])) begin
        st_d.load = !ld_busy;
      end
    end
    // Staged table entry write
    if (wr_tbl) begin
      st_d.tbl = apb_req.pwdata;
    end
    // Status: set on a table write wins over the load-end clear
    if (!st_q.upstream) begin
      st_d.status = 1'b0;
    end else if (wr_tbl) begin
      st_d.status = 1'b1;
    end else if (ld_done) begin
      st_d.status = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '{VCRC_MAP_RST[7:1], VCRC_SEL_RST, VCRC_TBL_RST, 1'b0,
                3'h0, 1'b0, 1'b0, 32'h0, 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Table loader
  // ----------------------------------------------------------------
  vcrc_loader u_loader (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(st_q.load),
    .table_src(st_q.tbl),
    .table_active(arb_table_active),
    .busy(ld_busy),
    .done(ld_done)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = st_q.pslverr;
  assign apb_rsp.prdata = st_q.prdata;
  assign class_to_channel_map = {st_q.map, 1'b1};
  assign arb_scheme_select = st_q.sel;
  assign channel_identifier = VCRC_ID_VAL;
  assign channel_enable = VCRC_EN_VAL;
  assign arb_table_status = st_q.status;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic rd_ctrl_acc;
  assign rd_ctrl_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite
                       && (apb_req.paddr == VCRC_OFF_CTRL);

  property p_map_bit0;
    @(posedge clk_sys) disable iff (rst)
    class_to_channel_map[0] && $stable(class_to_channel_map[0]);
  endproperty
  a_map_bit0: assert property (p_map_bit0)
    else $error("map bit 0 is not held at one");

  property p_map_follows;
    @(posedge clk_sys) disable iff (rst)
    wr_ctrl |=> class_to_channel_map[7:1] == $past(apb_req.pwdata[7:1]);
  endproperty
  a_map_follows: assert property (p_map_follows)
    else $error("map output did not take the written value");

  property p_load_reads_zero;
    @(posedge clk_sys) disable iff (rst)
    rd_ctrl_acc |-> !apb_rsp.prdata[VCRC_LOAD_BIT];
  endproperty
  a_load_reads_zero: assert property (p_load_reads_zero)
    else $error("load bit read back as one");

  property p_fixed_fields;
    @(posedge clk_sys) disable iff (rst)
    rd_ctrl_acc |-> apb_rsp.prdata[31:24] == 8'h80;
  endproperty
  a_fixed_fields: assert property (p_fixed_fields)
    else $error("identifier or enable read wrong");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (rst)
    rd_ctrl_acc |-> (apb_rsp.prdata[15:8] == 8'h0)
                    && (apb_rsp.prdata[23:20] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits read nonzero");

  property p_load_start;
    @(posedge clk_sys) disable iff (rst)
    (wr_ctrl && apb_req.pwdata[VCRC_LOAD_BIT] && st_q.upstream && !ld_busy
     && apb_req.pwdata[VCRC_SEL_LSB +: 3] == VCRC_SEL_WRR32)
    |=> st_q.load ##5 ld_done;
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("load trigger did not start and finish a load");

  property p_load_guard;
    @(posedge clk_sys) disable iff (rst)
    st_q.load |-> st_q.upstream && st_q.sel == VCRC_SEL_WRR32;
  endproperty
  a_load_guard: assert property (p_load_guard)
    else $error("load started downstream or with unused table");

  property p_status_set;
    @(posedge clk_sys) disable iff (rst)
    (wr_tbl && st_q.upstream && st_d.upstream) |=> arb_table_status;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("status not set after table write");

  property p_status_down;
    @(posedge clk_sys) disable iff (rst)
    !$past(st_q.upstream) |-> !arb_table_status;
  endproperty
  a_status_down: assert property (p_status_down)
    else $error("status nonzero in a downstream port");

endmodule : vcrc_ctrl

// ---- vcrc_pkg.sv ----
package vcrc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] VCRC_OFF_CTRL = 12'h214;
  localparam logic [11:0] VCRC_OFF_STAT = 12'h218;
  localparam logic [11:0] VCRC_OFF_TBL = 12'h220;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VCRC_MAP_LSB = 0;
  localparam int VCRC_LOAD_BIT = 16;
  localparam int VCRC_SEL_LSB = 17;
  localparam int VCRC_ID_LSB = 24;
  localparam int VCRC_EN_BIT = 31;
  localparam int VCRC_STAT_BIT = 16;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] VCRC_MAP_RST = 8'hff;
  localparam logic [2:0] VCRC_SEL_RST = 3'h0;
  localparam logic [2:0] VCRC_ID_VAL = 3'h0;
  localparam logic VCRC_EN_VAL = 1'h1;
  localparam logic [31:0] VCRC_TBL_RST = 32'h0065_4321;
  localparam logic [7:0] VCRC_CAP_UP = 8'h03;
  localparam logic [7:0] VCRC_CAP_DOWN = 8'h01;
  localparam logic [2:0] VCRC_SEL_WRR32 = 3'h1;
  localparam logic [2:0] VCRC_LOAD_CYCLES = 3'h4;

  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vcrc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vcrc_apb_rsp_t;

  // True when the selected scheme is supported and uses the table
  function automatic logic vcrc_table_used(input logic upstream,
                                           input logic [2:0] sel);
    logic [7:0] cap;
    cap = upstream ? VCRC_CAP_UP : VCRC_CAP_DOWN;
    return (sel == VCRC_SEL_WRR32) && cap[sel];
  endfunction : vcrc_table_used

endpackage : vcrc_pkg

// ---- vcrc_loader.sv ----
`timescale 1ns/1ps
module vcrc_loader (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] table_src,
  output logic [31:0] table_active,
  output logic busy,
  output logic done
);
  import vcrc_pkg::*;

  typedef enum logic {VCRC_LD_IDLE, VCRC_LD_COPY} vcrc_ld_state_t;

  typedef struct packed {
    vcrc_ld_state_t state;
    logic [2:0] cnt;
    logic [31:0] tbl;
    logic done;
  } vcrc_ld_t;

  vcrc_ld_t st_q;
  vcrc_ld_t st_d;

  // ----------------------------------------------------------------
  // Load sequencer: latch table over a fixed number of cycles
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    case (st_q.state)
      VCRC_LD_IDLE: begin
        if (start) begin
          st_d.state = VCRC_LD_COPY;
          st_d.cnt = VCRC_LOAD_CYCLES - 3'h1;
        end
      end
      VCRC_LD_COPY: begin
        if (st_q.cnt == 3'h0) begin
          st_d.tbl = table_src;
          st_d.done = 1'b1;
          st_d.state = VCRC_LD_IDLE;
        end else begin
          st_d.cnt = st_q.cnt - 3'h1;
        end
      end
      default: st_d.state = VCRC_LD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '{VCRC_LD_IDLE, 3'h0, VCRC_TBL_RST, 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign table_active = st_q.tbl;
  assign busy = (st_q.state == VCRC_LD_COPY);
  assign done = st_q.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_load_finishes;
    @(posedge clk_sys) disable iff (rst)
    (start && !busy) |-> ##5 (done && table_active == $past(table_src));
  endproperty
  a_load_finishes: assert property (p_load_finishes)
    else $error("table load did not finish in five cycles");

endmodule : vcrc_loader

// ---- test_vc_resource_control_reg.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module test_vc_resource_control_reg;
  import vcrc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, outputs and reference model state
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic up_pin = 1'b0;
  vcrc_apb_req_t req = '0;
  vcrc_apb_rsp_t rsp;
  logic [7:0] map_o;
  logic [2:0] sel_o;
  logic [2:0] id_o;
  logic en_o;
  logic stat_o;
  logic [31:0] act_o;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h0000_0025;
  logic [31:0] rd;
  logic err;
  logic [7:0] map_m;
  logic [2:0] sel_m;
  logic [31:0] tbl_m;
  logic [31:0] act_m;
  logic stat_m;
  logic up_m;
  logic [3:0] no_ld [3] = '{4'h1, 4'h0, 4'h2};

  // Free-running system clock
  always #20 clk_sys = ~clk_sys;

  vcrc_ctrl u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .apb_req(req),
    .apb_rsp(rsp),
    .port_is_upstream_pin(up_pin),
    .class_to_channel_map(map_o),
    .arb_scheme_select(sel_o),
    .channel_identifier(id_o),
    .channel_enable(en_o),
    .arb_table_active(act_o),
    .arb_table_status(stat_o)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Random source, fixed start value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected control word from the model
  function automatic logic [31:0] ctrl_m();
    return {1'b1, 4'h0, 3'h0, 4'h0, sel_m, 1'b0, 8'h00, map_m};
  endfunction : ctrl_m

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Write and update the model
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK(err, 1'b0)
    if (a == 12'h214) begin
      map_m = {d[7:1], 1'b1};
      sel_m = d[19:17];
    end
    if (a == 12'h220) begin
      tbl_m = d;
      stat_m = up_m;
    end
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rd_chk

  // Compare all outputs once the last write has landed
  task automatic chk_out();
    @(posedge clk_sys);
    `CHK(map_o, map_m)
    `CHK(map_o[0], 1'b1)
    `CHK(sel_o, sel_m)
    `CHK(id_o, 3'h0)
    `CHK(en_o, 1'b1)
    `CHK(act_o, act_m)
    `CHK(stat_o, stat_m)
  endtask : chk_out

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    map_m = 8'hff;
    sel_m = 3'h0;
    tbl_m = 32'h0065_4321;
    act_m = tbl_m;
    stat_m = 1'b0;
    up_m = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    // Reset values, downstream strap
    chk_out();
    rd_chk(12'h214, ctrl_m());
    rd_chk(12'h218, 32'h0000_0000);
    rd_chk(12'h220, tbl_m);
    // Random writes with the load bit set, downstream must not load
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      // Downstream may only select the fixed scheme, so select stays zero
      wr(12'h214, (seed & 32'hfff1_ffff) | 32'h0001_0000);
      seed = lfsr(seed);
      wr(12'h220, seed);
      repeat (4) @(posedge clk_sys);
      chk_out();
      rd_chk(12'h214, ctrl_m());
    end
    // Unmapped access and a write to the status word
    apb(1'b0, 12'h21c, 32'h0000_0000);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, 12'h21c, 32'hffff_ffff);
    `CHK(err, 1'b1)
    wr(12'h218, 32'hffff_ffff);
    rd_chk(12'h218, 32'h0000_0000);
    rd_chk(12'h214, ctrl_m());
    // Upstream strap: table write sets status
    up_pin <= 1'b1;
    up_m = 1'b1;
    repeat (8) @(posedge clk_sys);
    seed = lfsr(seed);
    wr(12'h220, seed);
    chk_out();
    // Writes that must not load: wrong scheme or trigger clear
    foreach (no_ld[k]) begin
      wr(12'h214, {12'h000, no_ld[k], 16'h00aa});
      repeat (6) @(posedge clk_sys);
      chk_out();
      `CHK(act_o, act_m)
    end
    // Real load with table scheme selected
    wr(12'h214, 32'h0003_00f0);
    rd_chk(12'h218, 32'h0001_0000);
    repeat (2) @(posedge clk_sys);
    `CHK(act_o, act_m)
    @(posedge clk_sys);
    act_m = tbl_m;
    stat_m = 1'b0;
    `CHK(act_o, act_m)
    chk_out();
    rd_chk(12'h214, ctrl_m());
    rd_chk(12'h218, 32'h0000_0000);
    print_verdict();
  end
endmodule : test_vc_resource_control_reg
